// *** ipc_defines.vh ***
// Purpose: constants for the interrupt priority and external pin select block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: sources indexed 0..NSRC-1, lower index wins among equal priority
// Behaviour
// - each source has its own priority bit, low by default after reset.
// - a high request may preempt a low routine; nothing preempts a high routine.
// - after a preempting high routine returns, the preempted low routine resumes.
// - among simultaneous requests the higher priority level is served first.
// - among equal-level simultaneous requests a fixed source order decides.
// - pending requests are sampled and priority decoded on every clock.
// - fastest response is 7 clocks: detect, one instruction, 5-clock call.
// - a request pending at return-from-interrupt waits one more instruction.
// - worst response is 19 clocks: detect, 5 return, 8 divide, 5 call.
// - a request waits while an equal or higher routine runs, through its return.
// - ext_irq_b polarity bit 7: 0 active low, 1 active high.
// - bits 6:4 select port 0 pin 0..7 for ext_irq_b.
// - ext_irq_a polarity bit 3: 0 active low, 1 active high.
// - bits 2:0 select port 0 pin 0..7 for ext_irq_a.
// - external inputs observe their pins without driving or disturbing them.
`ifndef IPC_DEFINES_VH
`define IPC_DEFINES_VH
`define IPC_NSRC 16
`define IPC_ADDR_CFG 12'he4
`define IPC_ADDR_PRIO 12'h100
`define IPC_ADDR_STAT 12'h104
`define IPC_ADDR_MASK 12'h108
`define IPC_ADDR_ACTV 12'h10c
`define IPC_CFG_RESET 8'h01
`define IPC_B_POL 7
`define IPC_B_SEL_HI 6
`define IPC_B_SEL_LO 4
`define IPC_A_POL 3
`define IPC_A_SEL_HI 2
`define IPC_A_SEL_LO 0
`define IPC_DETECT_CYC 4'd1
`define IPC_INSTR_CYC 4'd1
`define IPC_CALL_CYC 4'd5
`define IPC_MIN_RESP 7
`define IPC_MAX_RESP 19
`endif

// *** ipc_irq_prio.v ***
// Purpose: two-level interrupt arbitration plus external pin select
// Assumes: CPU reports instruction ends and returns; sources are levels
// Notes: vectorValid pulses when the call to a routine starts
`timescale 1ns/1ps
`default_nettype none
`include "ipc_defines.vh"
module ipc_irq_prio (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [13:0] periphReq,
  input wire [7:0] port0Pin,
  input wire instrDone,
  input wire retiDone,
  output reg vectorValid,
  output reg [3:0] vectorNum,
  output reg callBusy,
  output wire irq
);
  localparam NS = `IPC_NSRC;
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_CALL = 2'd2;

  reg [7:0] cfg_r;
  reg [NS-1:0] prio_r;
  reg [NS-1:0] stat_r;
  reg [NS-1:0] mask_r;
  reg [7:0] pinMeta_r;
  reg [7:0] pinSync_r;
  reg [NS-1:0] pend_r;
  reg actLow_r;
  reg actHigh_r;
  reg [1:0] state_r;
  reg [3:0] cnt_r;
  reg [3:0] selNum_r;
  reg selHigh_r;

  wire wrEn = psel && penable && pwrite;
  wire rdEn = psel && penable && !pwrite;
  wire hitCfg = paddr == `IPC_ADDR_CFG;
  wire hitPrio = paddr == `IPC_ADDR_PRIO;
  wire hitStat = paddr == `IPC_ADDR_STAT;
  wire hitMask = paddr == `IPC_ADDR_MASK;
  wire hitActv = paddr == `IPC_ADDR_ACTV;
  wire hitAny = hitCfg | hitPrio | hitStat | hitMask | hitActv;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hitAny;

  // polarity: bit set means active high
  function pinLevel;
    input [7:0] pins;
    input [2:0] sel;
    input pol;
    begin
      pinLevel = pins[sel] ~^ pol;
    end
  endfunction

  // lowest index among a vector
  function [4:0] firstSet;
    input [NS-1:0] v;
    integer i;
    begin
      firstSet = 5'h10;
      for (i = NS - 1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          firstSet = i[4:0];
        end
      end
    end
  endfunction

  wire extA = pinLevel(pinSync_r, cfg_r[`IPC_A_SEL_HI:`IPC_A_SEL_LO], cfg_r[`IPC_A_POL]);
  wire extB = pinLevel(pinSync_r, cfg_r[`IPC_B_SEL_HI:`IPC_B_SEL_LO], cfg_r[`IPC_B_POL]);
  wire [NS-1:0] rawReq = {periphReq, extB, extA};

  // candidates allowed by current activity
  wire [NS-1:0] hiCand = pend_r & prio_r;
  wire [NS-1:0] loCand = pend_r & ~prio_r;
  wire hiOk = !actHigh_r;
  wire loOk = !actHigh_r && !actLow_r;
  wire [4:0] hiPick = firstSet(hiCand);
  wire [4:0] loPick = firstSet(loCand);
  wire hiAvail = hiOk && !hiPick[4];
  wire loAvail = loOk && !loPick[4];
  wire anyAvail = hiAvail || loAvail;
  wire [3:0] pickNum = hiAvail ? hiPick[3:0] : loPick[3:0];

  assign irq = |(stat_r & mask_r);

  always @(posedge clk) begin
    if (rst) begin
      pinMeta_r <= 8'h00;
      pinSync_r <= 8'h00;
    end else begin
      pinMeta_r <= port0Pin;
      pinSync_r <= pinMeta_r;
    end
  end

  // register file
  always @(posedge clk) begin
    if (rst) begin
      cfg_r <= `IPC_CFG_RESET;
      prio_r <= {NS{1'b0}};
      mask_r <= {NS{1'b0}};
      stat_r <= {NS{1'b0}};
    end else begin
      if (wrEn && hitCfg) begin
        cfg_r <= pwdata[7:0];
      end
      if (wrEn && hitPrio) begin
        prio_r <= pwdata[NS-1:0];
      end
      if (wrEn && hitMask) begin
        mask_r <= pwdata[NS-1:0];
      end
      // set wins over write-one-to-clear
      stat_r <= (stat_r & ~((wrEn && hitStat) ? pwdata[NS-1:0] : {NS{1'b0}})) | rawReq;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= 32'h00000000;
      if (paddr == `IPC_ADDR_CFG) begin
        prdata <= {24'h000000, cfg_r};
      end else if (paddr == `IPC_ADDR_PRIO) begin
        prdata <= {16'h0000, prio_r};
      end else if (paddr == `IPC_ADDR_STAT) begin
        prdata <= {16'h0000, stat_r};
      end else if (paddr == `IPC_ADDR_MASK) begin
        prdata <= {16'h0000, mask_r};
      end else if (paddr == `IPC_ADDR_ACTV) begin
        prdata <= {26'h0000000, state_r, 2'b00, actHigh_r, actLow_r};
      end
    end
  end

  // arbitration and call sequencing
  always @(posedge clk) begin
    if (rst) begin
      pend_r <= {NS{1'b0}};
      actLow_r <= 1'b0;
      actHigh_r <= 1'b0;
      state_r <= ST_IDLE;
      cnt_r <= 4'd0;
      selNum_r <= 4'd0;
      selHigh_r <= 1'b0;
      vectorValid <= 1'b0;
      vectorNum <= 4'd0;
      callBusy <= 1'b0;
    end else begin
      pend_r <= rawReq;
      vectorValid <= 1'b0;
      if (retiDone) begin
        if (actHigh_r) begin
          actHigh_r <= 1'b0;
        end else begin
          actLow_r <= 1'b0;
        end
      end
      case (state_r)
        ST_IDLE: begin
          if (anyAvail) begin
            selNum_r <= pickNum;
            selHigh_r <= hiAvail;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // one instruction completes before the call; a return itself never counts
          if (instrDone && !retiDone) begin
            state_r <= ST_CALL;
            cnt_r <= `IPC_CALL_CYC;
            callBusy <= 1'b1;
            vectorValid <= 1'b1;
            vectorNum <= selNum_r;
            if (selHigh_r) begin
              actHigh_r <= 1'b1;
            end else begin
              actLow_r <= 1'b1;
            end
          end
        end
        ST_CALL: begin
          if (cnt_r == 4'd1) begin
            callBusy <= 1'b0;
            state_r <= ST_IDLE;
          end
          cnt_r <= cnt_r - 4'd1;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** ipc_irq_prio_chk.sv ***
// Purpose: port checker for the interrupt block
// Assumes: one clock, sync reset
// Notes: bound to ipc_irq_prio
`timescale 1ns/1ps
`default_nettype none
module ipc_irq_prio_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic instrDone,
  input wire logic retiDone,
  input wire logic vectorValid,
  input wire logic [3:0] vectorNum,
  input wire logic callBusy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_call;
    callBusy [*5] ##1 !callBusy;
  endsequence
  a_call_five: assert property (vectorValid |-> s_call)
    else $error("call length wrong");
  a_vec_pulse: assert property (vectorValid |=> !vectorValid)
    else $error("vector pulse too long");
  a_vec_after_instr: assert property (vectorValid |-> $past(instrDone))
    else $error("vector without instruction end");
  a_no_vec_return_from_interrupt_instr: assert property (vectorValid |-> !$past(retiDone))
    else $error("vector right after return");
  a_num_holds: assert property (!vectorValid |-> $stable(vectorNum))
    else $error("vector number moved");
  a_no_back_call: assert property ($past(callBusy) |-> !vectorValid)
    else $error("call inside call");
  a_busy_from_vec: assert property ($rose(callBusy) |-> vectorValid)
    else $error("call without vector");
  a_cfg_mapped: assert property (psel && penable && paddr == 12'he4 |-> !pslverr)
    else $error("config access refused");
endmodule
bind ipc_irq_prio ipc_irq_prio_chk i_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr), .instrDone(instrDone),
  .retiDone(retiDone), .vectorValid(vectorValid), .vectorNum(vectorNum), .callBusy(callBusy));
`default_nettype wire

// *** ipc_cpu_model.sv ***
// Purpose: core model ending instructions and routines
// Assumes: routine is four instructions
// Notes: gap sets instruction spacing
`timescale 1ns/1ps
`default_nettype none
module ipc_cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic callBusy,
  input wire logic vectorValid,
  input wire logic [3:0] gap,
  output logic instrDone,
  output logic retiDone
);
  logic [3:0] tick;
  logic [1:0] depth;
  logic [2:0] left;
  always @(posedge clk) begin
    instrDone <= 0;
    retiDone <= 0;
    if (rst) begin
      tick <= 0;
      depth <= 0;
      left <= 0;
    end else if (vectorValid) begin
      depth <= depth + 1;
      left <= 4;
      tick <= 0;
    end else if (!callBusy && tick >= gap) begin
      tick <= 0;
      instrDone <= 1;
      if (depth != 0 && left == 1) begin
        retiDone <= 1;
        depth <= depth - 1;
        left <= 4;
      end else if (left != 0) left <= left - 1;
    end else tick <= tick + 1;
  end
endmodule
`default_nettype wire

// *** interrupt_priority_and_ext_pin_select_test.sv ***
// Purpose: self-checking bench for ipc_irq_prio
// Assumes: zero wait APB
// Notes: vectors checked against a queue
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_and_ext_pin_select_test;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, instrDone, retiDone;
  logic vectorValid, callBusy, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] periphReq;
  logic [7:0] port0Pin;
  logic [3:0] vectorNum, gap;
  logic [2:0] selA, selB;
  logic [3:0] expQ[$];
  int miscompares = 0;
  int check_count = 0;
  ipc_irq_prio i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periphReq(periphReq), .port0Pin(port0Pin), .instrDone(instrDone), .retiDone(retiDone),
    .vectorValid(vectorValid), .vectorNum(vectorNum), .callBusy(callBusy), .irq(irq));
  ipc_cpu_model i_cpu (.clk(clk), .rst(rst), .callBusy(callBusy), .vectorValid(vectorValid),
    .gap(gap), .instrDone(instrDone), .retiDone(retiDone));
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task drain;
    repeat (600) if (expQ.size() != 0) @(posedge clk);
    chk(expQ.size(), 0);
    repeat (80) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (!rst && vectorValid === 1'b1) begin
      chk(vectorNum, expQ.size() ? expQ.pop_front() : 4'hx);
      if (vectorNum > 1) periphReq[vectorNum - 2] <= 0;
      else if (vectorNum == 1) port0Pin[selB] <= 0;
      else port0Pin[selA] <= 1;
    end
  end
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done;
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    periphReq = 14'h0000;
    port0Pin = 8'hff;
    gap = 1;
    void'($urandom(64130));
    repeat (6) @(posedge clk);
    rst <= 0;
    apb(0, 12'he4, 0);
    chk(rd, 32'h01);
    apb(0, 12'h100, 0);
    chk(rd, 0);
    apb(1, 12'h200, 32'hffff);
    chk(err, 1);
    apb(1, 12'h108, 32'hffff);
    for (int i = 0; i < 2; i++) begin
      apb(1, 12'h100, i ? 32'h200 : 0);
      expQ = i ? '{4'h9, 4'h5} : '{4'h5, 4'h9};
      periphReq <= 14'h88;
      drain;
    end
    gap <= 3;
    expQ = '{4'h4, 4'h9, 4'h3};
    periphReq <= 14'h04;
    while (expQ.size() == 3) @(posedge clk);
    periphReq <= 14'h82;
    drain;
    selA = $urandom % 8;
    selB = selA ^ 3'h5;
    apb(1, 12'he4, {24'h0, 1'b0, selB, 1'b0, selA});
    expQ = '{4'h0};
    port0Pin[selA] <= 0;
    drain;
    expQ = '{4'h1};
    apb(1, 12'he4, {24'h0, 1'b1, selB, 1'b0, selA});
    drain;
    chk(irq, 1);
    apb(0, 12'h104, 0);
    chk(rd, 32'h23b);
    apb(1, 12'h104, 32'hffff);
    @(posedge clk);
    chk(irq, 0);
    test_done;
  end
endmodule
`default_nettype wire
